/* File: hdl/rotate_right_no_carry_exec.sv */
// Execution datapath for the rotate-right-without-carry instruction
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Rotate operand right one place; bit 0 wraps to bit 7; carry untouched.
// - Destination bit 0: result goes to working register, file register kept.
// - Destination bit 1: result written back to the same file register.
// - Access bit 0, except the indexed case below: operand in access bank, bank-select register ignored.
// - Access bit 1: operand bank taken from the bank-select register.
// - Extended set, access 0, address <= 95: indexed literal offset addressing.
module rotate_right_no_carry_exec (
    // Clock and reset
    input  wire logic                                 mclk,
    input  wire logic                                 nrst,
    // Instruction issue
    input  wire logic                                 start,
    input  wire logic [rrnc_pkg::ADDR_W-1:0]          fileAddr,
    input  wire logic                                 destSel,
    input  wire logic                                 accessSel,
    input  wire logic [rrnc_pkg::BANK_W-1:0]          bank_select_register,
    input  wire logic                                 extendedEn,
    input  wire logic [rrnc_pkg::FULL_ADDR_W-1:0]     indexBase,
    // Data memory port
    output logic                                      memRdEn,
    output logic                                      memWrEn,
    output logic [rrnc_pkg::FULL_ADDR_W-1:0]          memAddr,
    output logic [rrnc_pkg::DATA_W-1:0]               memWrData,
    input  wire logic [rrnc_pkg::DATA_W-1:0]          memRdData,
    // Results
    output logic [rrnc_pkg::DATA_W-1:0]               workReg,
    output logic                                      workWrEn,
    output logic                                      negFlag,
    output logic                                      zeroFlag,
    output logic                                      flagWrEn,
    output logic                                      done
);
    import rrnc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    state_t                    state_q,     state_d;
    logic                      dest_q,      dest_d;
    logic                      memRdEn_q,   memRdEn_d;
    logic                      memWrEn_q,   memWrEn_d;
    logic [FULL_ADDR_W-1:0]    memAddr_q,   memAddr_d;
    logic [DATA_W-1:0]         memWrData_q, memWrData_d;
    logic [DATA_W-1:0]         workReg_q,   workReg_d;
    logic                      workWrEn_q,  workWrEn_d;
    logic                      negFlag_q,   negFlag_d;
    logic                      zeroFlag_q,  zeroFlag_d;
    logic                      flagWrEn_q,  flagWrEn_d;
    logic                      done_q,      done_d;
    logic [DATA_W-1:0]         rotated;
    logic [FULL_ADDR_W-1:0]    effAddr;

    // ------------------------------------------------------------
    // Operand address
    // ------------------------------------------------------------
    always_comb begin
        if (accessSel == ACC_BANKED) begin
            effAddr = {bank_select_register, fileAddr};
        end else if (extendedEn && (fileAddr <= LIT_OFFSET_MAX)) begin
            // Base plus literal offset; wraps inside the data space
            effAddr = indexBase + {4'h0, fileAddr};
        end else if (fileAddr < ACCESS_SPLIT) begin
            effAddr = {ACCESS_LO_BANK, fileAddr};
        end else begin
            effAddr = {ACCESS_HI_BANK, fileAddr};
        end
    end

    // No carry in or out: bit 0 wraps straight to bit 7
    assign rotated = {memRdData[0], memRdData[DATA_W-1:1]};

    // ------------------------------------------------------------
    // Sequencer: read, then write to destination
    // ------------------------------------------------------------
    always_comb begin
        state_d     = state_q;
        dest_d      = dest_q;
        memRdEn_d   = 1'b0;
        memWrEn_d   = 1'b0;
        memAddr_d   = memAddr_q;
        memWrData_d = memWrData_q;
        workReg_d   = workReg_q;
        workWrEn_d  = 1'b0;
        negFlag_d   = negFlag_q;
        zeroFlag_d  = zeroFlag_q;
        flagWrEn_d  = 1'b0;
        done_d      = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (start) begin
                    memAddr_d = effAddr;
                    memRdEn_d = 1'b1;
                    dest_d    = destSel;
                    state_d   = ST_READ;
                end
            end
            ST_READ: begin
                // Read data is valid the cycle after the strobe
                state_d = ST_WRITE;
            end
            ST_WRITE: begin
                if (dest_q == DEST_F) begin
                    memWrEn_d   = 1'b1;
                    memWrData_d = rotated;
                end else begin
                    workReg_d  = rotated;
                    workWrEn_d = 1'b1;
                end
                negFlag_d  = rotated[DATA_W-1];
                zeroFlag_d = (rotated == DATA_RST);
                flagWrEn_d = 1'b1;
                done_d     = 1'b1;
                state_d    = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_q     <= ST_IDLE;
            dest_q      <= DEST_W;
            memRdEn_q   <= 1'b0;
            memWrEn_q   <= 1'b0;
            memAddr_q   <= ADDR_RST;
            memWrData_q <= DATA_RST;
            workReg_q   <= DATA_RST;
            workWrEn_q  <= 1'b0;
            negFlag_q   <= 1'b0;
            zeroFlag_q  <= 1'b0;
            flagWrEn_q  <= 1'b0;
            done_q      <= 1'b0;
        end else begin
            state_q     <= state_d;
            dest_q      <= dest_d;
            memRdEn_q   <= memRdEn_d;
            memWrEn_q   <= memWrEn_d;
            memAddr_q   <= memAddr_d;
            memWrData_q <= memWrData_d;
            workReg_q   <= workReg_d;
            workWrEn_q  <= workWrEn_d;
            negFlag_q   <= negFlag_d;
            zeroFlag_q  <= zeroFlag_d;
            flagWrEn_q  <= flagWrEn_d;
            done_q      <= done_d;
        end
    end

    assign memRdEn   = memRdEn_q;
    assign memWrEn   = memWrEn_q;
    assign memAddr   = memAddr_q;
    assign memWrData = memWrData_q;
    assign workReg   = workReg_q;
    assign workWrEn  = workWrEn_q;
    assign negFlag   = negFlag_q;
    assign zeroFlag  = zeroFlag_q;
    assign flagWrEn  = flagWrEn_q;
    assign done      = done_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_rotate_to_reg;
        @(posedge mclk) disable iff (!nrst)
        (state_q == ST_WRITE && dest_q == DEST_F) |=>
            memWrEn && memWrData == {$past(memRdData[0]), $past(memRdData[7:1])};
    endproperty
    a_rotate_to_reg: assert property (p_rotate_to_reg) else $error("bad rotate to file");

    property p_dest_w;
        @(posedge mclk) disable iff (!nrst)
        (state_q == ST_WRITE && dest_q == DEST_W) |=>
            workWrEn && !memWrEn && workReg == {$past(memRdData[0]), $past(memRdData[7:1])};
    endproperty
    a_dest_w: assert property (p_dest_w) else $error("bad working register result");

    property p_dest_f;
        @(posedge mclk) disable iff (!nrst)
        (start && state_q == ST_IDLE && destSel) |=> ##2 (memWrEn && !workWrEn);
    endproperty
    a_dest_f: assert property (p_dest_f) else $error("file write missing");

    property p_same_addr;
        @(posedge mclk) disable iff (!nrst)
        memRdEn |=> ##1 (memAddr == $past(memAddr, 2));
    endproperty
    a_same_addr: assert property (p_same_addr) else $error("write address moved");

    property p_access_bank;
        @(posedge mclk) disable iff (!nrst)
        (start && state_q == ST_IDLE && !accessSel && !extendedEn && fileAddr < ACCESS_SPLIT)
            |=> memAddr == {4'h0, $past(fileAddr)};
    endproperty
    a_access_bank: assert property (p_access_bank) else $error("access bank address wrong");

    // Above the split no literal offset applies, so the top bank is used
    property p_access_high;
        @(posedge mclk) disable iff (!nrst)
        (start && state_q == ST_IDLE && !accessSel && fileAddr >= ACCESS_SPLIT)
            |=> memAddr == {ACCESS_HI_BANK, $past(fileAddr)};
    endproperty
    a_access_high: assert property (p_access_high) else $error("upper bank wrong");

    property p_banked;
        @(posedge mclk) disable iff (!nrst)
        (start && state_q == ST_IDLE && accessSel)
            |=> memAddr == {$past(bank_select_register), $past(fileAddr)};
    endproperty
    a_banked: assert property (p_banked) else $error("banked address wrong");

    property p_indexed;
        @(posedge mclk) disable iff (!nrst)
        (start && state_q == ST_IDLE && !accessSel && extendedEn && fileAddr <= 8'h5f)
            |=> memAddr == 12'($past(indexBase) + {4'h0, $past(fileAddr)});
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed address wrong");

    property p_flags;
        @(posedge mclk) disable iff (!nrst)
        flagWrEn |-> (negFlag == (memWrEn ? memWrData[7] : workReg[7]))
            && (zeroFlag == ((memWrEn ? memWrData : workReg) == 8'h00));
    endproperty
    a_flags: assert property (p_flags) else $error("status flags wrong");

    c_dest_w:  cover property (@(posedge mclk) disable iff (!nrst) workWrEn);
    c_dest_f:  cover property (@(posedge mclk) disable iff (!nrst) memWrEn);
    c_indexed: cover property (@(posedge mclk) disable iff (!nrst)
        start && state_q == ST_IDLE && !accessSel && extendedEn && fileAddr <= 8'h5f);
    c_zero:    cover property (@(posedge mclk) disable iff (!nrst) flagWrEn && zeroFlag);
endmodule

`default_nettype wire

/* File: hdl/rrnc_pkg.sv */
// Package: constants and types for the rotate-right-without-carry datapath
package rrnc_pkg;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned BANK_W       = 4;
    localparam int unsigned FULL_ADDR_W  = 12;
    localparam logic [7:0]  LIT_OFFSET_MAX = 8'h5f;   // Highest indexed literal offset
    localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;   // Access bank low/high split
    localparam logic [3:0]  ACCESS_HI_BANK = 4'hf;    // Upper access half maps to the top bank
    localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
    localparam logic [7:0]  DATA_RST     = 8'h00;
    localparam logic [11:0] ADDR_RST     = 12'h000;
    localparam logic        DEST_W       = 1'b0;
    localparam logic        DEST_F       = 1'b1;
    localparam logic        ACC_BANK     = 1'b0;
    localparam logic        ACC_BANKED   = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_READ  = 3'b010,
        ST_WRITE = 3'b100
    } state_t;
endpackage

/* File: testbench/rotate_right_no_carry_exec_tb.sv */
// Self-checking testbench for the rotate-right-without-carry datapath
`timescale 1ns/1ps
`default_nettype none

module rotate_right_no_carry_exec_tb;
    import rrnc_pkg::*;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  res;
        logic        dst;
    } note_t;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        mclk, nrst, start, destSel, accessSel, extendedEn;
    logic [7:0]  fileAddr, memRdData, workReg, memWrData;
    logic [3:0]  bankSel;
    logic [11:0] indexBase, memAddr;
    logic        memRdEn, memWrEn, workWrEn, negFlag, zeroFlag, flagWrEn, done;
    note_t       notes[$];
    int          badCount, comparisons, cycles;

    rotate_right_no_carry_exec u_dut (
        .mclk(mclk), .nrst(nrst), .start(start), .fileAddr(fileAddr),
        .destSel(destSel), .accessSel(accessSel), .bank_select_register(bankSel),
        .extendedEn(extendedEn), .indexBase(indexBase), .memRdEn(memRdEn),
        .memWrEn(memWrEn), .memAddr(memAddr), .memWrData(memWrData),
        .memRdData(memRdData), .workReg(workReg), .workWrEn(workWrEn),
        .negFlag(negFlag), .zeroFlag(zeroFlag), .flagWrEn(flagWrEn), .done(done)
    );

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ----------------------------------------
    // Compare and closing tasks
    // ----------------------------------------
    task automatic fail(input string msg);
        badCount++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask
    task automatic checkByte(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) fail($sformatf("%s got %h want %h", what, got, exp));
    endtask
    task automatic checkAddr(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp) fail($sformatf("address got %h want %h", got, exp));
    endtask
    task automatic checkBit(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) fail($sformatf("%s got %b want %b", what, got, exp));
    endtask
    task automatic wrapUp();
        $display("comparisons %0d mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Expected operand address, worked out independently of the design
    function automatic logic [11:0] effAddr(input logic [7:0] f, input logic a,
            input logic [3:0] b, input logic e, input logic [11:0] base);
        if (a) return {b, f};
        if (e && f <= LIT_OFFSET_MAX) return base + {4'h0, f};
        return (f < ACCESS_SPLIT) ? {ACCESS_LO_BANK, f} : {ACCESS_HI_BANK, f};
    endfunction

    // ----------------------------------------
    // Driver: issues one instruction and notes what must follow
    // ----------------------------------------
    task automatic issue(input logic [7:0] f, input logic d, input logic a,
            input logic [3:0] b, input logic e, input logic [11:0] base,
            input logic [7:0] v, input logic refuse);
        note_t n;
        n.addr = effAddr(f, a, b, e, base);
        n.res  = {v[0], v[7:1]};
        n.dst  = d;
        notes.push_back(n);
        fileAddr = f; destSel = d; accessSel = a; bankSel = b;
        extendedEn = e; indexBase = base; memRdData = ~v; start = 1'b1;
        @(posedge mclk);
        // Fields move once taken; a start held while busy must be dropped
        #2 start = refuse;
        fileAddr = ~f;
        accessSel = ~a;
        @(posedge mclk);
        // Read data stands only across the one edge that samples it
        #2 start = 1'b0;
        memRdData = v;
        @(posedge mclk);
        #2 memRdData = ~v;
        repeat (8) begin
            @(posedge mclk);
            if (done === 1'b1) break;
        end
        #2;
    endtask

    // ----------------------------------------
    // Monitor: compares results against the oldest note
    // ----------------------------------------
    always @(posedge mclk) begin
        if (nrst === 1'b1 && memRdEn === 1'b1) begin
            if (notes.size() == 0) fail("unexpected read");
            else checkAddr(memAddr, notes[0].addr);
        end
        if (nrst === 1'b1 && done === 1'b1) begin
            if (notes.size() == 0) fail("unexpected completion");
            else begin
                checkAddr(memAddr, notes[0].addr);
                checkBit(memWrEn, notes[0].dst, "file write");
                checkBit(workWrEn, ~notes[0].dst, "work write");
                if (notes[0].dst) checkByte(memWrData, notes[0].res, "file data");
                else checkByte(workReg, notes[0].res, "work data");
                checkBit(flagWrEn, 1'b1, "flag strobe");
                checkBit(negFlag, notes[0].res[7], "negative");
                checkBit(zeroFlag, notes[0].res == 8'h00, "zero");
                void'(notes.pop_front());
            end
        end
    end

    // Cut a hang short well past the expected run length
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            fail("timeout");
            wrapUp();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        nrst = 1'b0; start = 1'b0; fileAddr = 8'h00; destSel = 1'b0; accessSel = 1'b0;
        bankSel = 4'h0; extendedEn = 1'b0; indexBase = 12'h000; memRdData = 8'h00;
        repeat (20) @(posedge mclk);
        #2 checkBit(done, 1'b0, "done in reset");
        checkByte(workReg, DATA_RST, "work in reset");
        nrst = 1'b1;
        void'($urandom(33));
        issue(8'h10, 1'b1, 1'b0, 4'h3, 1'b0, 12'h000, 8'hd7, 1'b0);
        issue(8'h20, 1'b0, 1'b0, 4'h3, 1'b0, 12'h000, 8'h00, 1'b0);
        // Every d/a/extended combination on both sides of the offset boundary
        for (int k = 0; k < 16; k++) begin
            issue(k[3] ? 8'h60 : LIT_OFFSET_MAX, k[0], k[1], 4'h9, k[2], 12'hfd0,
                  8'h01 << k[2:0], 1'b0);
        end
        issue(8'h05, 1'b1, 1'b1, 4'h2, 1'b0, 12'h000, 8'h81, 1'b1);
        // Mid-run reset must clear address, file and work data, negative flag and done
        nrst = 1'b0;
        @(posedge mclk);
        #2 checkAddr(memAddr, ADDR_RST);
        checkByte(memWrData, DATA_RST, "file data after reset");
        checkByte(workReg, DATA_RST, "work after reset");
        checkBit(negFlag, 1'b0, "negative after reset");
        checkBit(done, 1'b0, "done after reset");
        nrst = 1'b1;
        for (int i = 0; i < 40; i++) begin
            issue($urandom, $urandom, $urandom, $urandom, $urandom, $urandom,
                  $urandom, $urandom);
        end
        repeat (4) @(posedge mclk);
        if (notes.size() != 0) fail("missing completions");
        wrapUp();
    end
endmodule

`default_nettype wire
